// ---- design/iqc_pkg.sv ----
// constants for the global command register and queue configuration sequencer
package iqc_pkg;
    localparam logic [7:0] IQC_GCMD_OFFSET = 8'h00;
    localparam logic [31:0] IQC_GCMD_RESET = 32'h0000_0200;
    localparam logic [31:0] IQC_GCMD_WMASK = 32'hff30_3e01;
    localparam int IQC_RX_CFG_LSB = 28;
    localparam int IQC_TX_CFG_LSB = 24;
    localparam int IQC_CFGQ_BIT = 21;
    localparam int IQC_PERQ_BIT = 20;
    localparam int IQC_POLL_LSB = 10;
    localparam int IQC_MASK_BIT = 9;
    localparam int IQC_AR_BIT = 0;
    localparam int IQC_NUM_QUEUES = 10;
    // queue ids: 0..3 rx ch0..3, 4..7 tx ch0..3, 8 config, 9 peripheral
    localparam logic [3:0] IQC_QID_RX0 = 4'h0;
    localparam logic [3:0] IQC_QID_TX0 = 4'h4;
    localparam logic [3:0] IQC_QID_CFG = 4'h8;
    localparam logic [3:0] IQC_QID_PER = 4'h9;
    typedef enum logic [2:0] {
        IQC_IDLE,
        IQC_SCAN,
        IQC_LOAD,
        IQC_CHAN_WAIT,
        IQC_REPORT
    } iqc_state_type;
endpackage

// ---- design/iqc_top.sv ----
// global command register and interrupt queue configuration sequencer
`timescale 1ns/1ps
`default_nettype none
module iqc_top
    import iqc_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int LEN_W = 32
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic [3:0] queue_sel,
    input wire logic [ADDR_W-1:0] queue_base,
    input wire logic [LEN_W-1:0] queue_len,
    output logic queue_setup_valid,
    output logic [3:0] queue_setup_id,
    output logic [ADDR_W-1:0] queue_setup_base,
    output logic [LEN_W-1:0] queue_setup_len,
    output logic chan_eval_start,
    input wire logic chan_busy,
    input wire logic chan_fail,
    output logic [3:0] tx_poll_request,
    output logic status_set_ack,
    output logic status_set_fail,
    output logic cfg_vec_valid,
    output logic cfg_vec_fail,
    output logic busy
);

    // alignment test needs two low base bits; lengths wider than a word are not served
    if (ADDR_W < 3 || ADDR_W > 64 || LEN_W < 1 || LEN_W > 32) begin : g_bad_width
        $error("iqc_top: unsupported ADDR_W or LEN_W");
    end

    // lowest pending queue goes first
    function automatic logic [3:0] iqc_first(input logic [IQC_NUM_QUEUES-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = IQC_NUM_QUEUES - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    iqc_state_type state_r, state_nxt;
    logic [31:0] gcmd_r;
    logic [IQC_NUM_QUEUES-1:0] pend_r;
    logic fail_r;
    logic [31:0] reg_rdata_r;
    logic [3:0] queue_sel_r;
    logic setup_valid_r;
    logic [3:0] setup_id_r;
    logic [ADDR_W-1:0] setup_base_r;
    logic [LEN_W-1:0] setup_len_r;
    logic chan_eval_r;
    logic [3:0] poll_r;
    logic set_ack_r;
    logic set_fail_r;
    logic vec_valid_r;
    logic vec_fail_r;
    logic busy_r;

    // only the command register is decoded; other offsets read zero
    wire hit = (reg_addr == IQC_GCMD_OFFSET);
    wire wr_hit = reg_wr && hit;
    wire idle = (state_r == IQC_IDLE);
    wire ar_write = wr_hit && reg_wdata[IQC_AR_BIT];
    // a request while busy is dropped; its other bits are still stored
    wire start = ar_write && idle;
    // command bits that are not self-clearing keep their written value
    wire [31:0] wr_keep = reg_wdata & IQC_GCMD_WMASK
        & ~(32'h0000_000f << IQC_POLL_LSB) & ~(32'h1 << IQC_AR_BIT);
    // queue order in the mask matches the queue id numbering
    wire [IQC_NUM_QUEUES-1:0] sel_mask = {
        gcmd_r[IQC_PERQ_BIT],
        gcmd_r[IQC_CFGQ_BIT],
        gcmd_r[IQC_TX_CFG_LSB +: 4],
        gcmd_r[IQC_RX_CFG_LSB +: 4]
    };
    // queue bits of the requesting write itself are used, not the stored copy
    wire [IQC_NUM_QUEUES-1:0] start_mask = wr_hit ? {
        reg_wdata[IQC_PERQ_BIT], reg_wdata[IQC_CFGQ_BIT],
        reg_wdata[IQC_TX_CFG_LSB +: 4], reg_wdata[IQC_RX_CFG_LSB +: 4]} : sel_mask;
    wire [3:0] next_q = iqc_first(pend_r);
    wire scan_pick = (state_r == IQC_SCAN) && (pend_r != '0);
    // zero length or a base off a dword boundary cannot hold vectors
    wire setup_bad = (queue_len == '0) || (queue_base[1:0] != 2'b00);
    // action request reads as one until the sequence has reported
    wire [31:0] rd_view = (gcmd_r & ~(32'h1 << IQC_AR_BIT))
        | ({31'h0, busy_r} << IQC_AR_BIT);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IQC_IDLE: begin
                if (start) begin
                    state_nxt = IQC_SCAN;
                end
            end
            IQC_SCAN: begin
                state_nxt = (pend_r == '0) ? IQC_CHAN_WAIT : IQC_LOAD;
            end
            IQC_LOAD: begin
                state_nxt = IQC_SCAN;
            end
            IQC_CHAN_WAIT: begin
                // channels get the eval pulse before their busy is trusted
                if (!chan_busy && !chan_eval_r) begin
                    state_nxt = IQC_REPORT;
                end
            end
            IQC_REPORT: begin
                state_nxt = IQC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= IQC_IDLE;
            gcmd_r <= IQC_GCMD_RESET;
            reg_rdata_r <= 32'h0000_0000;
            poll_r <= 4'h0;
        end else if (ce) begin
            state_r <= state_nxt;
            if (wr_hit) begin
                gcmd_r <= wr_keep;
            end
            poll_r <= wr_hit ? reg_wdata[IQC_POLL_LSB +: 4] : 4'h0;
            reg_rdata_r <= (reg_rd && hit) ? rd_view : 32'h0000_0000;
        end
    end

    // a failure sticks until the next start, so one bad queue fails all
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend_r <= '0;
            fail_r <= 1'b0;
            busy_r <= 1'b0;
            chan_eval_r <= 1'b0;
            queue_sel_r <= 4'h0;
        end else if (ce) begin
            chan_eval_r <= start;
            if (start) begin
                pend_r <= start_mask;
                fail_r <= 1'b0;
                busy_r <= 1'b1;
            end else if (scan_pick) begin
                queue_sel_r <= next_q;
                pend_r[next_q] <= 1'b0;
            end else if (state_r == IQC_LOAD && setup_bad) begin
                fail_r <= 1'b1;
            end else if (state_r == IQC_CHAN_WAIT && !chan_busy && chan_fail) begin
                fail_r <= 1'b1;
            end else if (state_r == IQC_REPORT) begin
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            setup_valid_r <= 1'b0;
            setup_id_r <= 4'h0;
            setup_base_r <= '0;
            setup_len_r <= '0;
        end else if (ce) begin
            // base and length are taken only once selection has settled
            setup_valid_r <= (state_r == IQC_LOAD);
            if (state_r == IQC_LOAD) begin
                setup_id_r <= queue_sel_r;
                setup_base_r <= queue_base;
                setup_len_r <= queue_len;
            end
        end
    end

    // result pulses come one edge after the report state
    wire report = (state_r == IQC_REPORT);

    // the mask is read at report time, not latched at the request

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            set_ack_r <= 1'b0;
            set_fail_r <= 1'b0;
            vec_valid_r <= 1'b0;
            vec_fail_r <= 1'b0;
        end else if (ce) begin
            set_ack_r <= report && !fail_r;
            set_fail_r <= report && fail_r;
            vec_valid_r <= report && !gcmd_r[IQC_MASK_BIT];
            if (report) begin
                vec_fail_r <= fail_r;
            end
        end
    end

    // every output is a flop; these only rename
    assign reg_rdata = reg_rdata_r;
    assign queue_sel = queue_sel_r;
    assign queue_setup_valid = setup_valid_r;
    assign queue_setup_id = setup_id_r;
    assign queue_setup_base = setup_base_r;
    assign queue_setup_len = setup_len_r;
    assign chan_eval_start = chan_eval_r;
    assign tx_poll_request = poll_r;
    assign status_set_ack = set_ack_r;
    assign status_set_fail = set_fail_r;
    assign cfg_vec_valid = vec_valid_r;
    assign cfg_vec_fail = vec_fail_r;
    assign busy = busy_r;

endmodule
`default_nettype wire

// ---- test/iqc_properties.sv ----
// checker for the command register and queue sequencer
`timescale 1ns/1ps
`default_nettype none
module iqc_properties (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic queue_setup_valid,
    input wire logic chan_eval_start,
    input wire logic [3:0] tx_poll_request,
    input wire logic status_set_ack,
    input wire logic status_set_fail,
    input wire logic cfg_vec_valid,
    input wire logic busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic mask_r;
    wire cmd_wr = ce && reg_wr && reg_addr == 8'h00;
    wire done = status_set_ack || status_set_fail;
    // shadow of the result mask, assumes no mask write while busy
    always_ff @(posedge clock or negedge rstn)
        if (!rstn) mask_r <= 1'b1;
        else if (cmd_wr) mask_r <= reg_wdata[9];
    ar_start_a: assert property (
        cmd_wr && reg_wdata[0] && !busy |=> busy && chan_eval_start) else $error("no start");
    // a frozen clock enable holds the pulse instead of clearing it
    poll_pulse_a: assert property (
        1'b1 |=> tx_poll_request == (!$past(ce) ? $past(tx_poll_request) :
            $past(cmd_wr) ? $past(reg_wdata[13:10]) : 4'h0))
        else $error("poll pulse wrong");
    result_one_a: assert property (!(status_set_ack && status_set_fail))
        else $error("two results");
    result_end_a: assert property (done |-> !busy && $past(busy))
        else $error("result misplaced");
    vec_masked_a: assert property (cfg_vec_valid |-> !mask_r && done)
        else $error("vector leaked");
    vec_open_a: assert property (done && !mask_r |-> cfg_vec_valid)
        else $error("vector lost");
    reserved_zero_a: assert property ((reg_rdata & 32'h00cf_c1fe) == 32'h0)
        else $error("reserved set");
    setup_busy_a: assert property (queue_setup_valid |-> busy)
        else $error("setup while idle");
    eval_rise_a: assert property ($rose(busy) |-> chan_eval_start)
        else $error("no eval");
endmodule
bind iqc_top iqc_properties u_iqc_properties (.clock(clock), .rstn(rstn), .ce(ce),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .queue_setup_valid(queue_setup_valid), .chan_eval_start(chan_eval_start),
    .tx_poll_request(tx_poll_request), .status_set_ack(status_set_ack),
    .status_set_fail(status_set_fail), .cfg_vec_valid(cfg_vec_valid), .busy(busy));
`default_nettype wire

// ---- test/irq_queue_config_command_bench.sv ----
// self-checking bench for the command register and queue sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED %0t mismatch", $time); end end
module irq_queue_config_command_bench;
    logic clock = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0, chan_busy = 0, chan_fail = 0;
    logic zl = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, queue_base, queue_len;
    logic [31:0] queue_setup_base, queue_setup_len;
    logic [3:0] queue_sel, queue_setup_id, tx_poll_request;
    logic queue_setup_valid, chan_eval_start, status_set_ack, status_set_fail;
    logic cfg_vec_valid, cfg_vec_fail, busy;
    int err_total = 0;
    int cmp_count = 0;
    // zl forces a zero length so the setup must fail
    assign queue_base = {24'h0, queue_sel, 4'h0};
    assign queue_len = zl ? 32'h0 : {28'h0, queue_sel} + 32'h1;
    iqc_top u_iqc_top (.clock(clock), .rstn(rstn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .queue_sel(queue_sel),
        .queue_base(queue_base), .queue_len(queue_len), .queue_setup_valid(queue_setup_valid),
        .queue_setup_id(queue_setup_id), .queue_setup_base(queue_setup_base),
        .queue_setup_len(queue_setup_len), .chan_eval_start(chan_eval_start),
        .chan_busy(chan_busy), .chan_fail(chan_fail), .tx_poll_request(tx_poll_request),
        .status_set_ack(status_set_ack), .status_set_fail(status_set_fail),
        .cfg_vec_valid(cfg_vec_valid), .cfg_vec_fail(cfg_vec_fail), .busy(busy));
    initial forever #12.5 clock = ~clock;
    task summarize;
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clock);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clock);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 0;
        `CHK(reg_rdata, exp)
    endtask
    task act(input logic [31:0] d, input logic [9:0] want, input logic fl, input int hold);
        logic [9:0] seen;
        int k;
        seen = 0;
        chan_busy = hold > 0;
        wr(8'h00, d);
        for (k = 0; k < 60 && !(status_set_ack || status_set_fail); k++) begin
            if (k == hold) chan_busy = 0;
            if (queue_setup_valid) begin
                `CHK(queue_setup_base, {24'h0, queue_setup_id, 4'h0})
                `CHK(queue_setup_len, (zl ? 32'h0 : {28'h0, queue_setup_id} + 32'h1))
                seen[queue_setup_id] = 1'b1;
            end
            @(negedge clock);
        end
        if (k == 60) begin
            err_total++;
            $display("CHECK FAILED %0t timeout", $time);
            summarize;
        end
        `CHK(seen, want)
        `CHK(k > hold, 1'b1)
        `CHK(status_set_fail, fl)
        `CHK(status_set_ack, ~fl)
        `CHK(busy, 1'b0)
        `CHK(cfg_vec_valid, ~d[9])
        `CHK(cfg_vec_fail | d[9], fl | d[9])
    endtask
    task t_fields;
        wr(8'h00, 32'hffff_fffe);
        `CHK(tx_poll_request, 4'hf)
        `CHK(busy, 1'b0)
        rd(8'h00, 32'hff30_0200);
        wr(8'h04, 32'h0);
        rd(8'h00, 32'hff30_0200);
        rd(8'h04, 32'h0);
        // a frozen clock enable must drop a write that carries a request
        ce = 0;
        wr(8'h00, 32'h0000_3c01);
        `CHK(tx_poll_request, 4'h0)
        `CHK(busy, 1'b0)
        ce = 1;
        rd(8'h00, 32'hff30_0200);
    endtask
    task t_reset;
        rd(8'h00, 32'h0000_0200);
    endtask
    task t_queues;
        act(32'hff30_0001, 10'h3ff, 1'b0, 0);
        act(32'h4220_0201, 10'h124, 1'b0, 3);
        rd(8'h00, 32'h4220_0200);
    endtask
    task t_fail;
        zl = 1;
        act(32'h1010_0001, 10'h201, 1'b1, 0);
        zl = 0;
        chan_fail = 1;
        act(32'h0800_0001, 10'h080, 1'b1, 4);
        chan_fail = 0;
    endtask
    initial begin
        repeat (12) @(negedge clock);
        rstn = 1;
        t_reset;
        t_fields;
        t_queues;
        t_fail;
        summarize;
    end
endmodule
`default_nettype wire
